// ---- hw/asp_uart.sv ----
// Asynchronous serial port with 8-bit and 9-bit frame formats and an
// AXI4-Lite register slave. Assumes baud_tick pulses one cycle at 16x the
// bit rate and that rx_line is already synchronous to clock.
//
// Overview of operation
// R01 - Transmit and receive run independently and at the same time.
// R02 - One control bit selects 8-bit or 9-bit frames for both directions.
// R03 - An 8-bit frame is start, eight data bits LSB first, then stop.
// R04 - An accepted 8-bit frame stores its data and its stop bit as extra.
// R05 - Writing a byte to the data buffer starts sending that byte; here it waits in a two-entry buffer while the transmitter is busy.
// R06 - The transmit-done flag sets at the start of the stop bit.
// R07 - No frame is accepted until receive enable is set.
// R08 - 8-bit frames load only with done clear and, if filtering, stop high.
// R09 - A load stores data and extra bit and sets done; else nothing moves.
// R10 - On overrun the first byte stays in the buffer, the new one is lost.
// R11 - With interrupts enabled, either done flag raises the request.
// R12 - A 9-bit frame is start, eight data bits, a ninth bit, then stop.
// R13 - The sent ninth bit is the software-written transmit ninth bit.
// R14 - In 9-bit frames the ninth bit is stored and the stop bit ignored.
// R15 - 9-bit frames load with done clear and, if filtering, ninth bit high.
// R16 - Bit timing uses the baud tick; a start is a falling idle line.
// R17 - Done flags hold until cleared; the transmit line idles high.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module asp_uart
  import asp_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic [ASP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ASP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  baud_tick,
  input  wire logic                  rx_line,
  output logic                       tx_line,
  output logic                       irq
);

  asp_ctrl_t                 ctrl;
  logic                      tx_done_flag;
  logic                      rx_done_flag;
  logic                      rx_ninth_bit;
  logic [7:0]                serial_data_buffer;
  logic [ASP_ADDR_W-1:0]     aw_addr;
  logic                      aw_held;
  logic [7:0]                w_data;
  logic                      w_lane0;
  logic                      w_held;
  asp_tx_state_t             tx_state;
  logic [3:0]                tx_cnt;
  logic [2:0]                tx_bitn;
  logic [7:0]                tx_shift;
  logic                      tx_ninth;
  logic                      tx_fmt9;
  asp_rx_state_t             rx_state;
  logic [3:0]                rx_cnt;
  logic [2:0]                rx_bitn;
  logic [7:0]                rx_shift;
  logic                      rx_ninth_s;
  logic                      rx_fmt9;
  logic                      rx_prev;
  logic [ASP_FIFO_W-1:0]     fifo_mem [ASP_FIFO_DEPTH];
  logic                      fifo_wptr;
  logic                      fifo_rptr;
  logic [1:0]                fifo_count;

  // Register bus decode
  wire       wr_both   = aw_held && w_held && !s_axi_bvalid;
  wire       sel_ctrl  = (aw_addr == ASP_OFF_CTRL);
  wire       sel_data  = (aw_addr == ASP_OFF_DATA);
  wire       sel_stat  = (aw_addr == ASP_OFF_STAT);
  wire       fifo_full = (fifo_count == 2'(ASP_FIFO_DEPTH));
  // A data write waits in place while the buffer is full, so software is
  // stalled on the bus instead of losing a byte.
  wire       wr_stall  = sel_data && w_lane0 && fifo_full;
  wire       wr_do     = wr_both && !wr_stall;
  wire       ctrl_wr   = wr_do && sel_ctrl && w_lane0;
  wire       fifo_push = wr_do && sel_data && w_lane0; // R05
  wire       wr_mapped = sel_ctrl || sel_data || sel_stat;
  wire       rd_take   = s_axi_arvalid && s_axi_arready;
  wire       rd_ctrl   = (s_axi_araddr == ASP_OFF_CTRL);
  wire       rd_data   = (s_axi_araddr == ASP_OFF_DATA);
  wire       rd_stat   = (s_axi_araddr == ASP_OFF_STAT);
  wire [7:0] ctrl_word = {ctrl.fmt9, ctrl.ien, ctrl.mpf, ctrl.ren,
                          ctrl.tb8, rx_ninth_bit, tx_done_flag,
                          rx_done_flag};
  wire [7:0] stat_word = {5'h00, (rx_state != ASP_RX_IDLE), fifo_full,
                          (tx_state != ASP_TX_IDLE)};
  wire [7:0] rd_byte   = rd_ctrl ? ctrl_word :
                         rd_data ? serial_data_buffer :
                         rd_stat ? stat_word : 8'h00;
  wire       rd_mapped = rd_ctrl || rd_data || rd_stat;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      w_held  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_do) begin
      w_held  <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ASP_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ASP_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control fields; hardware set wins over a software clear
  wire tx_done_set;
  wire rx_load;
  wire next_tx_done = tx_done_set || (ctrl_wr ? w_data[ASP_B_TI]
                                              : tx_done_flag); // R17
  wire next_rx_done = rx_load || (ctrl_wr ? w_data[ASP_B_RI]
                                          : rx_done_flag); // R17
  // Request follows the enable being written, so it never lags the flags
  wire next_ien     = ctrl_wr ? w_data[ASP_B_IEN] : ctrl.ien;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl         <= '0;
      tx_done_flag <= ASP_CTRL_RST[ASP_B_TI];
      rx_done_flag <= ASP_CTRL_RST[ASP_B_RI];
      irq          <= 1'b0;
    end else begin
      if (ctrl_wr)
        ctrl <= {w_data[ASP_B_FMT9], w_data[ASP_B_IEN], w_data[ASP_B_MPF],
                 w_data[ASP_B_REN], w_data[ASP_B_TB8]}; // R02
      tx_done_flag <= next_tx_done;
      rx_done_flag <= next_rx_done;
      irq          <= next_ien && (next_tx_done || next_rx_done); // R11
    end
  end

  // Two-entry transmit buffer
  wire                  fifo_valid = (fifo_count != 2'h0);
  wire                  fifo_pop   = fifo_valid && (tx_state == ASP_TX_IDLE);
  wire [ASP_FIFO_W-1:0] fifo_head  = fifo_mem[fifo_rptr];

  for (genvar i = 0; i < ASP_FIFO_DEPTH; i++) begin : g_fifo
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
        fifo_mem[i] <= '0;
      else if (fifo_push && (fifo_wptr == 1'(i)))
        fifo_mem[i] <= w_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fifo_wptr  <= 1'b0;
      fifo_rptr  <= 1'b0;
      fifo_count <= 2'h0;
    end else begin
      if (fifo_push)
        fifo_wptr <= !fifo_wptr;
      if (fifo_pop)
        fifo_rptr <= !fifo_rptr;
      fifo_count <= fifo_count + 2'(fifo_push) - 2'(fifo_pop);
    end
  end

  // Transmitter, independent of the receiver
  wire tx_bit_end = baud_tick && (tx_cnt == ASP_TICK_LAST); // R16
  wire tx_last    = (tx_bitn == ASP_BIT_LAST);
  assign tx_done_set = tx_bit_end && ((tx_state == ASP_TX_DATA && tx_last &&
                       !tx_fmt9) || (tx_state == ASP_TX_NINTH)); // R06

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= ASP_TX_IDLE;
      tx_cnt   <= 4'h0;
      tx_bitn  <= 3'h0;
      tx_shift <= 8'h00;
      tx_ninth <= 1'b0;
      tx_fmt9  <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      if (tx_state != ASP_TX_IDLE && baud_tick)
        tx_cnt <= tx_cnt + 4'h1;
      case (tx_state) // R01
        ASP_TX_IDLE: begin
          tx_line <= 1'b1; // R17
          tx_cnt  <= 4'h0;
          if (fifo_pop) begin
            tx_shift <= fifo_head;
            tx_ninth <= ctrl.tb8; // R13
            tx_fmt9  <= ctrl.fmt9; // R02
            tx_line  <= 1'b0; // R03
            tx_state <= ASP_TX_START;
          end
        end
        ASP_TX_START: begin
          if (tx_bit_end) begin
            tx_line  <= tx_shift[0];
            tx_bitn  <= 3'h0;
            tx_state <= ASP_TX_DATA;
          end
        end
        ASP_TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift <= {1'b0, tx_shift[7:1]}; // R03
            tx_bitn  <= tx_bitn + 3'h1;
            if (!tx_last) begin
              tx_line <= tx_shift[1];
            end else if (tx_fmt9) begin
              tx_line  <= tx_ninth; // R12
              tx_state <= ASP_TX_NINTH;
            end else begin
              tx_line  <= 1'b1;
              tx_state <= ASP_TX_STOP;
            end
          end
        end
        ASP_TX_NINTH: begin
          if (tx_bit_end) begin
            tx_line  <= 1'b1;
            tx_state <= ASP_TX_STOP;
          end
        end
        default: begin
          if (tx_bit_end)
            tx_state <= ASP_TX_IDLE;
        end
      endcase
    end
  end

  // Receiver samples each bit near its middle
  wire rx_bit_end = baud_tick && (rx_cnt == ASP_TICK_LAST);
  wire rx_mid     = baud_tick && (rx_cnt == ASP_TICK_HALF);
  wire rx_fall    = rx_prev && !rx_line; // R16
  wire rx_extra   = rx_fmt9 ? rx_ninth_s : rx_line; // R14
  // Overrun drops the new frame while the done flag is still up
  assign rx_load = (rx_state == ASP_RX_STOP) && rx_bit_end &&
                   !rx_done_flag && (!ctrl.mpf || rx_extra); // R08 R15 R10

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_buffer <= ASP_DATA_RST;
      rx_ninth_bit       <= ASP_CTRL_RST[ASP_B_RB8];
    end else if (rx_load) begin
      serial_data_buffer <= rx_shift; // R09
      rx_ninth_bit       <= rx_extra; // R04
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_state   <= ASP_RX_IDLE;
      rx_cnt     <= 4'h0;
      rx_bitn    <= 3'h0;
      rx_shift   <= 8'h00;
      rx_ninth_s <= 1'b0;
      rx_fmt9    <= 1'b0;
      rx_prev    <= 1'b1;
    end else begin
      rx_prev <= rx_line;
      if (rx_state != ASP_RX_IDLE && baud_tick)
        rx_cnt <= rx_cnt + 4'h1;
      case (rx_state) // R01
        ASP_RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (ctrl.ren && rx_fall) begin // R07
            rx_fmt9  <= ctrl.fmt9; // R02
            rx_state <= ASP_RX_START;
          end
        end
        ASP_RX_START: begin
          if (rx_mid) begin
            rx_cnt   <= 4'h0;
            rx_bitn  <= 3'h0;
            rx_state <= rx_line ? ASP_RX_IDLE : ASP_RX_DATA;
          end
        end
        ASP_RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift <= {rx_line, rx_shift[7:1]}; // R03
            rx_bitn  <= rx_bitn + 3'h1;
            if (rx_bitn == ASP_BIT_LAST)
              rx_state <= rx_fmt9 ? ASP_RX_NINTH : ASP_RX_STOP; // R12
          end
        end
        ASP_RX_NINTH: begin
          if (rx_bit_end) begin
            rx_ninth_s <= rx_line;
            rx_state   <= ASP_RX_STOP;
          end
        end
        default: begin
          if (rx_bit_end)
            rx_state <= ASP_RX_IDLE;
        end
      endcase
    end
  end

  sequence s_stop_sample;
    (rx_state == ASP_RX_STOP) && rx_bit_end;
  endsequence

  sequence s_data_end_8;
    (tx_state == ASP_TX_DATA) && tx_last && tx_bit_end && !tx_fmt9;
  endsequence

  AST_TX_IDLE_HIGH: assert property (@(posedge clock) disable iff (!rst_b) // R17
    (tx_state == ASP_TX_IDLE) && $past(tx_state == ASP_TX_IDLE) |-> tx_line)
    else $error("tx line not high while idle");
  AST_TX_START_LOW: assert property (@(posedge clock) disable iff (!rst_b) // R03
    fifo_pop |=> !tx_line && (tx_state == ASP_TX_START))
    else $error("start bit not driven low");
  AST_TX_DONE_AT_STOP: assert property (@(posedge clock) disable iff (!rst_b) // R06
    s_data_end_8 |=> tx_done_flag && tx_line && (tx_state == ASP_TX_STOP))
    else $error("tx done not set at stop bit");
  AST_TX_NINTH: assert property (@(posedge clock) disable iff (!rst_b) // R13
    (tx_state == ASP_TX_NINTH) |-> (tx_line == tx_ninth))
    else $error("ninth bit mismatch");
  AST_RX_DISABLED: assert property (@(posedge clock) disable iff (!rst_b) // R07
    (rx_state == ASP_RX_IDLE) && !ctrl.ren |=> (rx_state == ASP_RX_IDLE))
    else $error("receiver left idle while disabled");
  AST_RX_LOAD: assert property (@(posedge clock) disable iff (!rst_b) // R09
    s_stop_sample ##0 (!rx_done_flag && !ctrl.mpf) |=>
      rx_done_flag && (serial_data_buffer == $past(rx_shift)))
    else $error("accepted frame not stored");
  AST_RX_OVERRUN: assert property (@(posedge clock) disable iff (!rst_b) // R10
    rx_done_flag |=> $stable(serial_data_buffer) && $stable(rx_ninth_bit))
    else $error("buffer overwritten on overrun");
  AST_RX_FILTER: assert property (@(posedge clock) disable iff (!rst_b) // R15
    s_stop_sample ##0 (ctrl.mpf && !rx_extra && !rx_done_flag) |=>
      $stable(serial_data_buffer) && !rx_done_flag)
    else $error("filtered frame was loaded");
  AST_IRQ: assert property (@(posedge clock) disable iff (!rst_b) // R11
    ctrl.ien && (tx_done_flag || rx_done_flag) |-> irq)
    else $error("interrupt request missing");

endmodule // asp_uart

// ---- hw/asp_pkg.sv ----
// Constants, field layout and types for the asynchronous serial port.
// Assumes an AXI4-Lite master with 32-bit data and a 16x baud tick source.
package asp_pkg;
  localparam int          ASP_ADDR_W     = 4;
  localparam logic [3:0]  ASP_OFF_CTRL   = 4'h0;
  localparam logic [3:0]  ASP_OFF_DATA   = 4'h4;
  localparam logic [3:0]  ASP_OFF_STAT   = 4'h8;
  localparam logic [1:0]  ASP_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  ASP_RESP_SLVERR = 2'h2;

  // Bit positions in serial_control_reg
  localparam int ASP_B_FMT9 = 7;
  localparam int ASP_B_IEN  = 6;
  localparam int ASP_B_MPF  = 5;
  localparam int ASP_B_REN  = 4;
  localparam int ASP_B_TB8  = 3;
  localparam int ASP_B_RB8  = 2;
  localparam int ASP_B_TI   = 1;
  localparam int ASP_B_RI   = 0;
  // Bit positions in the status register
  localparam int ASP_B_TXBUSY = 0;
  localparam int ASP_B_FULL   = 1;
  localparam int ASP_B_RXBUSY = 2;

  localparam logic [7:0] ASP_CTRL_RST = 8'h00;
  localparam logic [7:0] ASP_DATA_RST = 8'h00;

  // Baud tick is 16 times the bit rate
  localparam logic [3:0] ASP_TICK_LAST = 4'hf;
  localparam logic [3:0] ASP_TICK_HALF = 4'h7;
  localparam logic [2:0] ASP_BIT_LAST  = 3'h7;

  localparam int ASP_FIFO_W     = 8;
  localparam int ASP_FIFO_DEPTH = 2;

  typedef struct packed {
    logic fmt9;
    logic ien;
    logic mpf;
    logic ren;
    logic tb8;
  } asp_ctrl_t;

  typedef enum logic [2:0] {
    ASP_TX_IDLE, ASP_TX_START, ASP_TX_DATA, ASP_TX_NINTH, ASP_TX_STOP
  } asp_tx_state_t;

  typedef enum logic [2:0] {
    ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_NINTH, ASP_RX_STOP
  } asp_rx_state_t;
endpackage

// ---- sim/asp_remote.sv ----
// Remote serial transceiver facing the port's line pins.
// Assumes baud_tick pulses at 16x the bit rate, as the port expects.
`timescale 1ns/1ps
module asp_remote (
  input  wire logic clock,
  input  wire logic baud_tick,
  input  wire logic fmt9,
  input  wire logic line_in,
  output logic      line_out
);
  logic [9:0] got_q [$];

  initial line_out = 1'b1;

  task automatic wait_ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clock);
      if (baud_tick === 1'b1) k++;
    end
  endtask

  // Stop level is a parameter so the port's stop-bit handling can be probed
  task automatic send_frame(input logic [7:0] d, input logic ninth,
                            input logic stop);
    logic [10:0] bits;
    int          n;
    bits = {stop, ninth, d, 1'b0};
    n = fmt9 ? 11 : 10;
    if (!fmt9) bits[9] = stop;
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      wait_ticks(16);
    end
    line_out <= 1'b1;
  endtask

  // Sampling mid-bit tolerates the one-cycle detection lag
  initial begin : rx_watch
    logic [9:0] w;
    int         n;
    forever begin
      @(posedge clock);
      if (line_in === 1'b0) begin
        w = 10'h3ff;
        n = fmt9 ? 10 : 9;
        wait_ticks(8);
        if (line_in === 1'b0) begin
          for (int i = 0; i < n; i++) begin
            wait_ticks(16);
            w[i] = line_in;
          end
          got_q.push_back(w);
        end
      end
    end
  end
endmodule // asp_remote

// ---- sim/test_async_serial_port_modes.sv ----
// Self-checking bench for the serial port: registers, both frame formats,
// filtering, overrun and the transmit buffer.
// Assumes the remote model drives rx_line and watches tx_line.
`timescale 1ns/1ps
module test_async_serial_port_modes;
  import asp_pkg::*;

  typedef struct packed {
    logic       fmt9;
    logic       mpf;
    logic       extra;
    logic [7:0] d;
    logic       load;
  } asp_row_t;

  localparam int LIMIT = 20000;

  logic                  clock, rst_b, rx_line, tx_line, irq;
  logic                  baud_tick = 1'b0;
  logic [3:0]            strb = 4'hf;
  logic                  fmt9, s_axi_awvalid, s_axi_awready;
  logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  logic [ASP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  int                    err_count, checks;
  int                    cycles = 0;
  asp_row_t              rows [6];

  asp_uart i_asp_uart (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .baud_tick, .rx_line, .tx_line, .irq
  );

  asp_remote i_asp_remote (
    .clock, .baud_tick, .fmt9, .line_in(tx_line), .line_out(rx_line)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Tick every other cycle keeps a frame at 320 cycles, or 352 with the ninth bit
  always @(posedge clock) begin
    baud_tick <= ~baud_tick;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done;
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_reg(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cmp_frame(input string s, input logic [9:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cmp_pin(input string s, input logic e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", s, e, g);
    end
  endtask

  task automatic wr(input logic [ASP_ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        cmp_reg("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        break;
      end
    end
  endtask

  task automatic rd(input string s, input logic [ASP_ADDR_W-1:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        cmp_reg(s, e, s_axi_rdata);
        cmp_reg("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        break;
      end
    end
  endtask

  function automatic logic [31:0] cw(input logic f, m, rn, t);
    cw = 32'h0;
    cw[ASP_B_FMT9] = f;
    cw[ASP_B_IEN]  = 1'b1;
    cw[ASP_B_MPF]  = m;
    cw[ASP_B_REN]  = rn;
    cw[ASP_B_TB8]  = t;
  endfunction

  task automatic wait_frames(input int n);
    while (i_asp_remote.got_q.size() < n) @(posedge clock);
  endtask

  initial begin : main
    logic [7:0] last_rx;
    logic       last_rb8;
    logic [7:0] tx_b [4];
    {rst_b, fmt9, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h0;
    s_axi_wdata = 32'h0;
    {err_count, checks} = '0;
    rows = '{'{1'b0, 1'b0, 1'b1, 8'ha5, 1'b1}, '{1'b0, 1'b1, 1'b0, 8'h3c, 1'b0},
             '{1'b0, 1'b1, 1'b1, 8'h81, 1'b1}, '{1'b1, 1'b0, 1'b0, 8'h5a, 1'b1},
             '{1'b1, 1'b1, 1'b0, 8'hc3, 1'b0}, '{1'b1, 1'b1, 1'b1, 8'h7e, 1'b1}};
    tx_b = '{8'h01, 8'h80, 8'hff, 8'h3c};
    last_rx = ASP_DATA_RST;
    last_rb8 = 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    cmp_pin("tx_line idle", 1'b1, tx_line);
    cmp_pin("irq", 1'b0, irq);
    rd("ctrl", ASP_OFF_CTRL, {24'h0, ASP_CTRL_RST}, ASP_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      asp_row_t w;
      w = rows[i];
      fmt9 <= w.fmt9;
      wr(ASP_OFF_CTRL, cw(w.fmt9, w.mpf, 1'b1, w.extra), ASP_RESP_OKAY);
      fork
        i_asp_remote.send_frame(w.d, w.extra, w.fmt9 ? ~w.extra : w.extra);
        wr(ASP_OFF_DATA, {24'h0, ~w.d}, ASP_RESP_OKAY);
      join
      wait_frames(1);
      if (w.load) begin
        last_rx = w.d;
        last_rb8 = w.extra;
      end
      cmp_frame("tx frame", {1'b1, w.fmt9 ? w.extra : 1'b1, ~w.d},
                i_asp_remote.got_q.pop_front());
      rd("ctrl", ASP_OFF_CTRL, cw(w.fmt9, w.mpf, 1'b1, w.extra) |
         {29'h0, last_rb8, 1'b1, w.load}, ASP_RESP_OKAY);
      rd("rx data", ASP_OFF_DATA, {24'h0, last_rx}, ASP_RESP_OKAY);
      cmp_pin("irq", 1'b1, irq);
    end
    fmt9 <= 1'b0;
    wr(ASP_OFF_CTRL, cw(1'b0, 1'b0, 1'b0, 1'b0), ASP_RESP_OKAY);
    i_asp_remote.send_frame(8'h96, 1'b1, 1'b1);
    rd("ctrl", ASP_OFF_CTRL, cw(1'b0, 1'b0, 1'b0, 1'b0) | {29'h0, last_rb8, 2'h0},
       ASP_RESP_OKAY);
    rd("rx data", ASP_OFF_DATA, {24'h0, last_rx}, ASP_RESP_OKAY);
    wr(ASP_OFF_CTRL, cw(1'b0, 1'b0, 1'b1, 1'b0), ASP_RESP_OKAY);
    i_asp_remote.send_frame(8'h11, 1'b1, 1'b1);
    i_asp_remote.send_frame(8'h22, 1'b0, 1'b0);
    rd("ctrl", ASP_OFF_CTRL, cw(1'b0, 1'b0, 1'b1, 1'b0) | 32'h5, ASP_RESP_OKAY);
    rd("rx data", ASP_OFF_DATA, 32'h11, ASP_RESP_OKAY);
    cmp_pin("irq", 1'b1, irq);
    wr(ASP_OFF_CTRL, cw(1'b0, 1'b0, 1'b1, 1'b0), ASP_RESP_OKAY);
    @(posedge clock);
    cmp_pin("irq cleared", 1'b0, irq);
    for (int k = 0; k < 3; k++) wr(ASP_OFF_DATA, {24'h0, tx_b[k]}, ASP_RESP_OKAY);
    rd("status", ASP_OFF_STAT, 32'h3, ASP_RESP_OKAY);
    wr(ASP_OFF_DATA, {24'h0, tx_b[3]}, ASP_RESP_OKAY);
    wait_frames(4);
    for (int k = 0; k < 4; k++)
      cmp_frame("queued frame", {2'b11, tx_b[k]}, i_asp_remote.got_q.pop_front());
    // Done flag set by software with the request masked, then unmasked
    wr(ASP_OFF_CTRL, 32'h1 << ASP_B_TI, ASP_RESP_OKAY);
    cmp_pin("irq masked", 1'b0, irq);
    wr(ASP_OFF_CTRL, 32'h1 << ASP_B_TI | 32'h1 << ASP_B_IEN, ASP_RESP_OKAY);
    cmp_pin("irq enabled", 1'b1, irq);
    strb = 4'he;
    wr(ASP_OFF_CTRL, 32'hff, ASP_RESP_OKAY);
    strb = 4'hf;
    rd("ctrl lane", ASP_OFF_CTRL, 32'h1 << ASP_B_TI | 32'h1 << ASP_B_IEN |
       32'h1 << ASP_B_RB8, ASP_RESP_OKAY);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    cmp_pin("irq after reset", 1'b0, irq);
    rd("ctrl after reset", ASP_OFF_CTRL, {24'h0, ASP_CTRL_RST}, ASP_RESP_OKAY);
    rd("data after reset", ASP_OFF_DATA, {24'h0, ASP_DATA_RST}, ASP_RESP_OKAY);
    wr(4'hc, 32'hff, ASP_RESP_SLVERR);
    rd("unmapped", 4'hc, 32'h0, ASP_RESP_SLVERR);
    test_done();
  end
endmodule // test_async_serial_port_modes
